// *** ctb_host_model.sv ***
// host model: two-wire bus master that reaches the settings bank
`timescale 1ns/1ps
`default_nettype none
module ctb_host_model (
   input  wire logic clk_sys,
   input  wire logic sda_line,
   output logic      scl_drv,
   output logic      sda_drv
);
   // ------------------------------------------------
   // bus phases; drv high means the line is released
   // ------------------------------------------------
   initial begin
      scl_drv = 1'h1;
      sda_drv = 1'h1;
   end
   // six clocks a phase stays above the synchroniser minimum
   task automatic half();
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic start();
      sda_drv <= 1'h1;
      half();
      scl_drv <= 1'h1;
      half();
      sda_drv <= 1'h0;
      half();
      scl_drv <= 1'h0;
      half();
   endtask
   task automatic stop();
      sda_drv <= 1'h0;
      half();
      scl_drv <= 1'h1;
      half();
      sda_drv <= 1'h1;
      half();
   endtask
   // data moves only mid-low, so no false start or stop
   task automatic xbit(input logic b, output logic r);
      sda_drv <= b;
      half();
      scl_drv <= 1'h1;
      half();
      r = sda_line;
      scl_drv <= 1'h0;
      half();
   endtask
   // a kick is a written one; the host sends it only when a test writes it, never on its own
   task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] q,
                        output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], r);
         q[i] = r;
      end
      xbit(mack, r);
      ack = ~r;
   endtask
endmodule
`default_nettype wire

// *** ctb_pkg.sv ***
// package: register map, field layout and carrier types of the charger timer/function bank
package ctb_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_TIMER_SETTINGS      = 8'h06;
   localparam logic [7:0] OFS_FUNCTION_SETTINGS_A = 8'h07;
   localparam logic [7:0] OFS_FUNCTION_SETTINGS_B = 8'h08;

   // ---------------------------------------------------------------
   // values after reset and writable-bit masks
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_TIMER_SETTINGS      = 8'h38;
   localparam logic [7:0] RST_FUNCTION_SETTINGS_A = 8'h04;
   localparam logic [7:0] RST_FUNCTION_SETTINGS_B = 8'h00;
   localparam logic [7:0] MSK_TIMER_SETTINGS      = 8'h3E;
   localparam logic [7:0] MSK_FUNCTION_SETTINGS_A = 8'h7D;
   localparam logic [7:0] MSK_FUNCTION_SETTINGS_B = 8'hFF;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int TS_CHARGE_COMPLETE_TIMER_ON = 5;
   localparam int TS_PRECHARGE_FAST_TIMER_ON  = 4;
   localparam int TS_CHARGE_TIMER_LONG_SEL    = 3;
   localparam int TS_SAFETY_WATCHDOG_ON       = 2;
   localparam int TS_SAFETY_WATCHDOG_LONG_SEL = 1;
   localparam int TS_SAFETY_WATCHDOG_KICK     = 0;
   localparam int FA_DEVICE_DISABLE           = 6;
   localparam int FA_BATTERY_MONITOR_FORCE_ON = 5;
   localparam int FA_THERMISTOR_SRC_FORCE_ON  = 4;
   localparam int FA_LINEAR_REGULATOR_OFF     = 3;
   localparam int FA_END_OF_CHARGE_ALLOW      = 2;
   localparam int FA_CHARGING_ENABLE          = 0;
   localparam int FB_TEMP_PROFILE_ENABLE      = 7;
   localparam int FB_TEMP_PROFILE_SELECT      = 6;
   localparam int FB_CHARGE_VOLTAGE_LIMIT_ON  = 5;
   localparam int FB_IDEAL_DIODE_LSB          = 3;
   localparam int FB_SYSTEM_VOLTAGE_LSB       = 0;

   // ---------------------------------------------------------------
   // encodings and scale
   // ---------------------------------------------------------------
   localparam logic [1:0]  DIODE_ALWAYS       = 2'h0;
   localparam logic [1:0]  DIODE_ABOVE_WEAK   = 2'h1;
   localparam logic [12:0] SYS_VOLT_BASE_MV   = 13'h10CC;
   localparam logic [12:0] SYS_VOLT_STEP_MV   = 13'h0064;
   localparam logic [3:0]  BITS_PER_BYTE      = 4'h8;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_ACK  = 6'h04,
      ST_RX   = 6'h08,
      ST_TX   = 6'h10,
      ST_RACK = 6'h20
   } ctb_state_t;

   typedef struct packed {
      logic vin_ok;
      logic batt_above_weak;
      logic sys_below_bat;
      logic batt_below_vlim;
   } ctb_sense_t;

   typedef struct packed {
      logic        charge_complete_timer_full;
      logic        precharge_fast_timer_run;
      logic        charge_timer_long_sel;
      logic        safety_watchdog_run;
      logic        safety_watchdog_long_sel;
      logic        charger_on;
      logic        battery_monitor_on;
      logic        thermistor_source_on;
      logic        regulator_on;
      logic        iso_switch_force_on;
      logic        iso_switch_force_off;
      logic        end_of_charge_allow;
      logic        charging_allowed;
      logic        temp_profile_on;
      logic        temp_profile_select;
      logic        ideal_diode_on;
      logic [2:0]  system_voltage_code;
      logic [12:0] system_voltage_mv;
   } ctb_ctrl_t;

endpackage

// *** ctb_regs.sv ***
// charger timer and function settings bank behind the two-wire serial port
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - 31 ms deglitch always runs; the set bit enables the full charge-complete timer.
// R2 - trickle and fast timers run only while their enable bit is set; resets to 1.
// R3 - period bit: 0 gives 30 s / 300 min, 1 gives 60 s / 600 min; resets to 1.
// R4 - watchdog stays off while its enable is 0, even above weak level; resets 0.
// R5 - watchdog period bit picks 32 s or 64 s; safety timer stays 40 min.
// R6 - writing one to the kick bit restarts the watchdog; host kicks it periodically; the bench host kicks only when a test writes one.
// R7 - device-disable bit disables the whole charger; zero after reset.
// R8 - battery monitor on with input supply good, else only when forced.
// R9 - thermistor source on with input supply good, else only when forced.
// R10 - regulator-off bit stops regulator; isolation switch on if charging off, else off.
// R11 - end of charge is allowed only while its allow bit is set; resets to 1.
// R12 - charging only while charge enable is one; resets to zero.
// R13 - temperature-profile compliance applies only while its enable is set; resets 0.
// R14 - profile select: 0 first variant (reset), 1 second variant.
// R15 - with voltage limit set, charging waits until battery drops below the limit.
// R16 - diode mode 00 always, 01 also needs above-weak, 10 and 11 disabled.
// R17 - system voltage code 000..111 gives 4.3 V to 5.0 V in 0.1 V steps.
// R18 - weak battery threshold is a rising threshold, default 3.0 V.
// R19 - kick bit holds nothing and reads zero; unused bits read zero, ignore writes.
// R20 - writes reach controls the cycle after the write completes; reset restores defaults.
module ctb_regs
   import ctb_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary value
) (
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire ctb_sense_t sense_in,
   output ctb_ctrl_t       ctrl,
   output logic            safety_watchdog_kick
);

   // ---------------------------------------------------------------
   // elaboration check
   // ---------------------------------------------------------------
   generate
      if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_bad_addr
         $error("device address falls in a reserved range");
      end
   endgenerate

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic       scl_s1, scl_s2, scl_s3;
   logic       sda_s1, sda_s2, sda_s3;
   ctb_sense_t sense_s1, sense_s2;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         scl_s1   <= 1'b1;
         scl_s2   <= 1'b1;
         scl_s3   <= 1'b1;
         sda_s1   <= 1'b1;
         sda_s2   <= 1'b1;
         sda_s3   <= 1'b1;
         sense_s1 <= '0;
         sense_s2 <= '0;
      end else begin
         scl_s1   <= scl_in;
         scl_s2   <= scl_s1;
         scl_s3   <= scl_s2;
         sda_s1   <= sda_in;
         sda_s2   <= sda_s1;
         sda_s3   <= sda_s2;
         sense_s1 <= sense_in;
         sense_s2 <= sense_s1;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise  = scl_s2 & ~scl_s3;
   assign scl_fall  = ~scl_s2 & scl_s3;
   assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

   // ---------------------------------------------------------------
   // register bank state
   // ---------------------------------------------------------------
   logic [7:0] timer_settings_reg,      timer_settings_next;
   logic [7:0] function_settings_a_reg, function_settings_a_next;
   logic [7:0] function_settings_b_reg, function_settings_b_next;
   logic       kick_reg,                kick_next;
   ctb_ctrl_t  ctrl_reg,                ctrl_next;

   function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [7:0] t,
                                            input logic [7:0] fa, input logic [7:0] fb);
      unique case (a)
         OFS_TIMER_SETTINGS:      read_byte = t & MSK_TIMER_SETTINGS;  // R19
         OFS_FUNCTION_SETTINGS_A: read_byte = fa & MSK_FUNCTION_SETTINGS_A;
         OFS_FUNCTION_SETTINGS_B: read_byte = fb;
         default:                 read_byte = 8'h00;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // serial slave state machine
   // ---------------------------------------------------------------
   ctb_state_t st_reg,    st_next;
   logic [3:0] cnt_reg,   cnt_next;
   logic [7:0] sh_reg,    sh_next;
   logic [7:0] ptr_reg,   ptr_next;
   logic       phase_reg, phase_next;
   logic       rd_reg,    rd_next;
   logic       oe_reg,    oe_next;
   logic       nack_reg,  nack_next;
   logic       wr_en;
   logic [7:0] tx_byte;

   assign tx_byte = read_byte(ptr_reg, timer_settings_reg, function_settings_a_reg,
                              function_settings_b_reg);

   always_comb begin
      st_next    = st_reg;
      cnt_next   = cnt_reg;
      sh_next    = sh_reg;
      ptr_next   = ptr_reg;
      phase_next = phase_reg;
      rd_next    = rd_reg;
      oe_next    = oe_reg;
      nack_next  = nack_reg;
      wr_en      = 1'b0;
      if (bus_start) begin
         st_next    = ST_ADDR;
         cnt_next   = 4'h0;
         phase_next = 1'b1;
         oe_next    = 1'b0;
      end else if (bus_stop) begin
         st_next = ST_IDLE;
         oe_next = 1'b0;
      end else begin
         unique case (st_reg)
            ST_IDLE: begin
               oe_next = 1'b0;
            end
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  sh_next  = {sh_reg[6:0], sda_s2};
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
                  cnt_next = 4'h0;
                  st_next  = ST_ACK;
                  oe_next  = 1'b1;
                  if (st_reg == ST_ADDR) begin
                     rd_next = sh_reg[0];
                     if (sh_reg[7:1] != DEV_ADDR) begin
                        st_next = ST_IDLE;
                        oe_next = 1'b0;
                     end
                  end else if (phase_reg) begin
                     ptr_next   = sh_reg;
                     phase_next = 1'b0;
                  end else begin
                     wr_en    = 1'b1;
                     ptr_next = ptr_reg + 8'h01;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (rd_reg) begin
                     st_next  = ST_TX;
                     sh_next  = tx_byte;
                     ptr_next = ptr_reg + 8'h01;
                     oe_next  = ~tx_byte[7];
                  end else begin
                     st_next = ST_RX;
                     oe_next = 1'b0;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_reg == BITS_PER_BYTE) begin
                     st_next  = ST_RACK;
                     cnt_next = 4'h0;
                     oe_next  = 1'b0;
                  end else begin
                     sh_next = {sh_reg[6:0], 1'b0};
                     oe_next = ~sh_reg[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  nack_next = sda_s2;
               end else if (scl_fall) begin
                  if (nack_reg) begin
                     st_next = ST_IDLE;
                  end else begin
                     st_next  = ST_TX;
                     sh_next  = tx_byte;
                     ptr_next = ptr_reg + 8'h01;
                     oe_next  = ~tx_byte[7];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_reg    <= ST_IDLE;
         cnt_reg   <= 4'h0;
         sh_reg    <= 8'h00;
         ptr_reg   <= 8'h00;
         phase_reg <= 1'b0;
         rd_reg    <= 1'b0;
         oe_reg    <= 1'b0;
         nack_reg  <= 1'b0;
      end else begin
         st_reg    <= st_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         ptr_reg   <= ptr_next;
         phase_reg <= phase_next;
         rd_reg    <= rd_next;
         oe_reg    <= oe_next;
         nack_reg  <= nack_next;
      end
   end

   // open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe  = oe_reg;

   // ---------------------------------------------------------------
   // register writes and derived controls
   // ---------------------------------------------------------------
   logic [1:0] diode_mode;

   always_comb begin
      timer_settings_next      = timer_settings_reg;
      function_settings_a_next = function_settings_a_reg;
      function_settings_b_next = function_settings_b_reg;
      kick_next                = 1'b0;
      if (wr_en) begin
         unique case (ptr_reg)
            OFS_TIMER_SETTINGS: begin
               timer_settings_next = sh_reg & MSK_TIMER_SETTINGS;  // R19
               kick_next = sh_reg[TS_SAFETY_WATCHDOG_KICK];  // R6
            end
            OFS_FUNCTION_SETTINGS_A: function_settings_a_next = sh_reg & MSK_FUNCTION_SETTINGS_A;
            OFS_FUNCTION_SETTINGS_B: function_settings_b_next = sh_reg;
            default: ;  // unmapped writes are dropped
         endcase
      end
      // controls follow the next register values so they change one edge after the write
      diode_mode = function_settings_b_next[FB_IDEAL_DIODE_LSB +: 2];
      ctrl_next.charge_complete_timer_full =
         timer_settings_next[TS_CHARGE_COMPLETE_TIMER_ON];  // R1
      ctrl_next.precharge_fast_timer_run =
         timer_settings_next[TS_PRECHARGE_FAST_TIMER_ON];  // R2
      ctrl_next.charge_timer_long_sel = timer_settings_next[TS_CHARGE_TIMER_LONG_SEL];  // R3
      ctrl_next.safety_watchdog_run = timer_settings_next[TS_SAFETY_WATCHDOG_ON]
                                      & sense_s2.batt_above_weak;  // R4 R18
      ctrl_next.safety_watchdog_long_sel =
         timer_settings_next[TS_SAFETY_WATCHDOG_LONG_SEL];  // R5
      ctrl_next.charger_on = ~function_settings_a_next[FA_DEVICE_DISABLE];  // R7
      ctrl_next.battery_monitor_on = sense_s2.vin_ok
         | function_settings_a_next[FA_BATTERY_MONITOR_FORCE_ON];  // R8
      ctrl_next.thermistor_source_on = sense_s2.vin_ok
         | function_settings_a_next[FA_THERMISTOR_SRC_FORCE_ON];  // R9
      ctrl_next.regulator_on = ~function_settings_a_next[FA_LINEAR_REGULATOR_OFF]
                               & ~function_settings_a_next[FA_DEVICE_DISABLE];  // R10
      ctrl_next.iso_switch_force_on = function_settings_a_next[FA_LINEAR_REGULATOR_OFF]
                                      & ~function_settings_a_next[FA_CHARGING_ENABLE];  // R10
      ctrl_next.iso_switch_force_off = function_settings_a_next[FA_LINEAR_REGULATOR_OFF]
                                       & function_settings_a_next[FA_CHARGING_ENABLE];  // R10
      ctrl_next.end_of_charge_allow = function_settings_a_next[FA_END_OF_CHARGE_ALLOW];  // R11
      ctrl_next.charging_allowed = function_settings_a_next[FA_CHARGING_ENABLE]  // R12
         & ~function_settings_a_next[FA_DEVICE_DISABLE]
         & (~function_settings_b_next[FB_CHARGE_VOLTAGE_LIMIT_ON]
            | sense_s2.batt_below_vlim);  // R15
      ctrl_next.temp_profile_on = function_settings_b_next[FB_TEMP_PROFILE_ENABLE];  // R13
      ctrl_next.temp_profile_select = function_settings_b_next[FB_TEMP_PROFILE_SELECT];  // R14
      ctrl_next.ideal_diode_on = (diode_mode == DIODE_ALWAYS && sense_s2.sys_below_bat)
         | (diode_mode == DIODE_ABOVE_WEAK && sense_s2.sys_below_bat
            && sense_s2.batt_above_weak);  // R16
      ctrl_next.system_voltage_code =
         function_settings_b_next[FB_SYSTEM_VOLTAGE_LSB +: 3];  // R17
      ctrl_next.system_voltage_mv = SYS_VOLT_BASE_MV
         + SYS_VOLT_STEP_MV * {10'h000, function_settings_b_next[FB_SYSTEM_VOLTAGE_LSB +: 3]};
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         timer_settings_reg      <= RST_TIMER_SETTINGS;  // R20
         function_settings_a_reg <= RST_FUNCTION_SETTINGS_A;
         function_settings_b_reg <= RST_FUNCTION_SETTINGS_B;
         kick_reg                <= 1'b0;
         ctrl_reg                <= '0;
      end else begin
         timer_settings_reg      <= timer_settings_next;  // R20
         function_settings_a_reg <= function_settings_a_next;
         function_settings_b_reg <= function_settings_b_next;
         kick_reg                <= kick_next;
         ctrl_reg                <= ctrl_next;
      end
   end

   assign ctrl                 = ctrl_reg;
   assign safety_watchdog_kick = kick_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_kick_write;
      wr_en && ptr_reg == OFS_TIMER_SETTINGS && sh_reg[TS_SAFETY_WATCHDOG_KICK];
   endsequence

   a_kick_pulse_once: assert property (s_kick_write
      |=> safety_watchdog_kick ##1 !safety_watchdog_kick)  // R6
      else $error("kick write did not give a single pulse");
   a_kick_only_write: assert property (safety_watchdog_kick |-> $past(wr_en))  // R6
      else $error("kick pulse without a write");
   a_kick_reads_zero: assert property (timer_settings_reg[TS_SAFETY_WATCHDOG_KICK] == 1'b0)  // R19
      else $error("kick bit holds a value");
   a_write_effect: assert property (wr_en && ptr_reg == OFS_FUNCTION_SETTINGS_B
      |=> ctrl.system_voltage_code == $past(sh_reg[2:0]))  // R20
      else $error("write not visible next cycle");
   a_charge_gate: assert property (ctrl.charging_allowed
      |-> function_settings_a_reg[FA_CHARGING_ENABLE] && ctrl.charger_on)  // R12
      else $error("charging without enable");
   a_iso_switch: assert property (ctrl.iso_switch_force_on
      |-> !ctrl.regulator_on && !ctrl.iso_switch_force_off)  // R10
      else $error("isolation switch state wrong");
   a_diode_off: assert property (function_settings_b_reg[4] |-> !ctrl.ideal_diode_on)  // R16
      else $error("ideal diode on in disabled mode");
   // ctrl lags the synced sense by one register, so look one cycle back
   a_monitor_force: assert property (!$past(sense_s2.vin_ok)
      && !function_settings_a_reg[FA_BATTERY_MONITOR_FORCE_ON]
      |-> !ctrl.battery_monitor_on)  // R8
      else $error("battery monitor on without cause");
   a_watchdog_gate: assert property (!timer_settings_reg[TS_SAFETY_WATCHDOG_ON]
      |-> !ctrl.safety_watchdog_run)  // R4
      else $error("watchdog runs while disabled");
   a_reset_defaults: assert property ($rose(resetn)
      |-> timer_settings_reg == RST_TIMER_SETTINGS && !ctrl.charging_allowed)  // R20
      else $error("defaults not restored");

endmodule

`default_nettype wire

// *** tb_ctb_regs.sv ***
// self-checking bench of the charger timer and function settings bank
`timescale 1ns/1ps
`default_nettype none
module tb_ctb_regs;
   import ctb_pkg::*;
   // ------------------------------------------------
   // harness
   // ------------------------------------------------
   localparam logic [6:0] DEV = 7'h2A;  // arbitrary value
   logic       clk_sys = 1'h0;
   logic       resetn = 1'h0;
   ctb_sense_t sense = '0;
   ctb_ctrl_t  ctrl;
   logic       sda_out, sda_oe, kick, scl_drv, sda_drv, sda_line, ack;
   logic [7:0] q;
   int         error_cnt = 0;
   int         total_checks = 0;
   int         kick_cnt = 0;
   always #2 clk_sys = ~clk_sys;
   // pull-up wins unless someone pulls low
   assign sda_line = (sda_oe ? sda_out : 1'h1) & sda_drv;
   always @(posedge clk_sys) if (kick === 1'h1) kick_cnt++;
   ctb_regs #(.DEV_ADDR(DEV)) i_dut (
      .clk_sys              (clk_sys),
      .resetn               (resetn),
      .scl_in               (scl_drv),
      .sda_in               (sda_line),
      .sda_out              (sda_out),
      .sda_oe               (sda_oe),
      .sense_in             (sense),
      .ctrl                 (ctrl),
      .safety_watchdog_kick (kick)
   );
   ctb_host_model i_host (
      .clk_sys  (clk_sys),
      .sda_line (sda_line),
      .scl_drv  (scl_drv),
      .sda_drv  (sda_drv)
   );
   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      i_host.start();
      i_host.xbyte({DEV, 1'h0}, 1'h1, q, ack);
      check("address ack", 32'h1, {31'h0, ack});
      i_host.xbyte(ptr, 1'h1, q, ack);
      i_host.xbyte(d, 1'h1, q, ack);
      i_host.stop();
   endtask
   task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
      i_host.start();
      i_host.xbyte({DEV, 1'h0}, 1'h1, q, ack);
      i_host.xbyte(ptr, 1'h1, q, ack);
      i_host.start();
      i_host.xbyte({DEV, 1'h1}, 1'h1, q, ack);
      i_host.xbyte(8'hFF, 1'h1, q, ack);
      i_host.stop();
      check("read data", {24'h0, exp}, {24'h0, q});
   endtask
   // sense passes two sync flops and a register before it shows
   task automatic set_sense(input logic [3:0] s);
      @(posedge clk_sys);
      sense <= ctb_sense_t'(s);
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic do_reset();
      @(posedge clk_sys);
      resetn <= 1'h0;
      repeat (5) @(posedge clk_sys);
      resetn <= 1'h1;
      repeat (4) @(posedge clk_sys);
   endtask
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_defaults();
      set_sense(4'h0);
      rd(8'h06, 8'h38);
      rd(8'h07, 8'h04);
      rd(8'h08, 8'h00);
      check("ctrl default", {16'hE490, 3'h0, 13'h10CC}, ctrl);
   endtask
   task automatic t_timer();
      int k;
      set_sense(4'h4);
      k = kick_cnt;
      wr(8'h06, 8'hC7);
      check("timer ctrl", {27'h0, 5'h03}, {27'h0, ctrl[31:27]});
      check("kick count", k + 1, kick_cnt);
      rd(8'h06, 8'h06);
      set_sense(4'h0);
      check("watchdog below weak", 32'h0, {31'h0, ctrl[28]});
      set_sense(4'h4);
      wr(8'h06, 8'h3A);
      check("timer ctrl", {27'h0, 5'h1D}, {27'h0, ctrl[31:27]});
      check("kick count", k + 1, kick_cnt);
   endtask
   task automatic fa(input logic [7:0] d, input logic [3:0] s, input logic [7:0] e);
      set_sense(s);
      wr(8'h07, d);
      check("function a ctrl", {24'h0, e}, {24'h0, ctrl[26:19]});
   endtask
   task automatic t_func_a();
      fa(8'h70, 4'h0, 8'h60);
      fa(8'h09, 4'h8, 8'hE5);
      fa(8'h0C, 4'h0, 8'h8A);
      fa(8'h04, 4'h0, 8'h92);
      fa(8'h21, 4'h0, 8'hD1);
      fa(8'h11, 4'h0, 8'hB1);
   endtask
   task automatic t_func_b();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         wr(8'h08, {c[0], c[1], 3'h2, c});
         check("profile", {30'h0, c[0], c[1]}, {30'h0, ctrl[18:17]});
         check("sys voltage", {16'h0, c, 13'h10CC + 13'h0064 * c}, {16'h0, ctrl[15:0]});
      end
      for (int m = 0; m < 4; m++) begin
         for (int a = 0; a < 2; a++) begin
            set_sense({1'h0, a[0], 1'h1, 1'h0});
            wr(8'h08, {3'h0, 2'(m), 3'h0});
            check("ideal diode", {31'h0, m == 0 || (m == 1 && a == 1)}, {31'h0, ctrl[16]});
         end
      end
      set_sense(4'h4);
      wr(8'h08, 8'h00);
      check("ideal diode", 32'h0, {31'h0, ctrl[16]});
      wr(8'h07, 8'h01);
      wr(8'h08, 8'h20);
      set_sense(4'h0);
      check("limited charging", 32'h0, {31'h0, ctrl[19]});
      set_sense(4'h1);
      check("limited charging", 32'h1, {31'h0, ctrl[19]});
   endtask
   task automatic t_unused();
      wr(8'h07, 8'hFF);
      rd(8'h07, 8'h7D);
      wr(8'h09, 8'h5A);
      rd(8'h09, 8'h00);
      i_host.start();
      i_host.xbyte({DEV ^ 7'h01, 1'h0}, 1'h1, q, ack);
      i_host.stop();
      check("foreign address ack", 32'h0, {31'h0, ack});
   endtask
   initial begin
      do_reset();
      t_defaults();
      t_timer();
      t_func_a();
      t_func_b();
      t_unused();
      do_reset();
      t_defaults();
      final_report();
   end
   initial begin
      #360000;
      error_cnt++;
      final_report();
   end
endmodule
`default_nettype wire
